// ### cfg_fifo.sv
// Parameterised valid/ready FIFO; one clock.
`timescale 1ns/100ps
`default_nettype none
module cfg_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   output var  logic [WIDTH-1:0] out_data,
   output var  logic             out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   logic             push;
   logic             pop;

   assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
   assign out_valid = wr_q != rd_q;
   assign out_data  = mem[rd_q[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_q <= '0;
      end else if (push) begin
         wr_q <= wr_q + 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_q <= '0;
      end else if (pop) begin
         rd_q <= rd_q + 1'b1;
      end
   end
endmodule : cfg_fifo
`default_nettype wire

// ### cfg_link_if.sv
// Byte-wide configuration link between the source and one loader.
// Open-drain init line resolved here from the loader's enable.
`timescale 1ns/100ps
`default_nettype none
interface cfg_link_if;
   logic       config_clock;
   logic [7:0] config_byte_bus;
   logic       chain_select;
   logic       chain_status;
   logic       reconfig_b;
   logic [2:0] mode_select;
   logic       init_o;
   logic       init_oe;
   logic       init_b;
   logic       done;

   // Pulled up; only the loader pulls low
   assign init_b = init_oe ? init_o : 1'b1;

   modport loader (
      input  config_clock, config_byte_bus, chain_select, reconfig_b, mode_select, init_b,
      output chain_status, init_o, init_oe, done
   );
   modport source (
      output config_clock, config_byte_bus, chain_select, reconfig_b, mode_select,
      input  chain_status, init_b, done
   );
endinterface : cfg_link_if
`default_nettype wire

// ### cfg_link_sva.sv
// Assertions on the link between source and loader.
// Assumes the source makes config_clock from clk, so clk sees every level.
`timescale 1ns/100ps
`default_nettype none
module cfg_link_sva
   import cfg_loader_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       config_clock,
   input wire logic [7:0] config_byte_bus,
   input wire logic       chain_select,
   input wire logic       chain_status,
   input wire logic       reconfig_b,
   input wire logic [2:0] mode_select,
   input wire logic       init_o,
   input wire logic       init_oe,
   input wire logic       init_b,
   input wire logic       done
);
   logic       seen_q;
   logic [7:0] rise_cnt_q;
   logic       rise;

   assign rise = config_clock & ~seen_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         seen_q <= 1'b0;
      end else begin
         seen_q <= config_clock;
      end
   end

   // Saturates so a long stream cannot wrap back into the header window
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rise_cnt_q <= 8'h00;
      end else if (!reconfig_b) begin
         rise_cnt_q <= 8'h00;
      end else if (rise && rise_cnt_q != 8'hff) begin
         rise_cnt_q <= rise_cnt_q + 8'h01;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence quiet_restart;
      reconfig_b [*4];
   endsequence
   sequence preamble_edge;
      rise && rise_cnt_q == 8'h02;
   endsequence
   sequence hdr_check_edge;
      rise && rise_cnt_q == 8'h06;
   endsequence

   chk_init_open_drain: assert property (init_oe |-> !init_o && !init_b)
      else $error("init line driven high");
   chk_preamble_lines: assert property (preamble_edge |-> config_byte_bus == 8'h4f)
      else $error("preamble byte wrong on the lines");
   chk_header_check: assert property (hdr_check_edge |-> config_byte_bus == 8'h4b)
      else $error("end of header byte wrong");
   chk_status_after_header: assert property ($fell(chain_status) |-> rise_cnt_q >= 8'(HEADER_LEN))
      else $error("status fell before header end");
   chk_done_holds: assert property (quiet_restart ##0 done |=> done)
      else $error("done dropped without restart");
   chk_error_holds: assert property (quiet_restart ##0 init_oe |=> init_oe)
      else $error("init released without restart");
   chk_done_when_full: assert property ($rose(done) |-> chain_status && rise_cnt_q >= 8'(HEADER_LEN + STARTUP_MIN))
      else $error("done before full and start-up");
   chk_bus_steady_high: assert property (config_clock && seen_q |-> $stable(config_byte_bus))
      else $error("bus moved while link clock high");
   chk_link_period: assert property (rise |-> config_clock [*8] ##1 !config_clock)
      else $error("link clock high time wrong");
   chk_express_mode: assert property (mode_select == MODE_EXPRESS)
      else $error("mode pins not express");
endmodule : cfg_link_sva
`default_nettype wire

// ### cfg_loader.sv
// Loader end: parses the byte-wide express stream sampled from the link.
// Assumes link pins are asynchronous; each passes two flip-flops first.
`timescale 1ns/100ps
`default_nettype none
module cfg_loader
   import cfg_loader_pkg::*;
#(
   parameter int FRAME_LEN  = DEF_FRAME_LEN,
   parameter int NUM_FRAMES = DEF_FRAMES
) (
   input  wire logic clk,
   input  wire logic rst_b,
   cfg_link_if.loader link,
   output var  logic [7:0] frame_byte,
   output var  logic       frame_valid,
   output var  logic       frame_error,
   output var  logic       loaded
);
   initial begin
      if (FRAME_LEN < 1 || NUM_FRAMES < 1) $error("frame shape must be positive");
   end

   typedef enum logic [2:0] {
      S_HEADER = 3'b000,
      S_WAIT   = 3'b001,
      S_START  = 3'b011,
      S_DATA   = 3'b010,
      S_CHECK  = 3'b110,
      S_FULL   = 3'b111,
      S_ERROR  = 3'b100
   } state_type;

   state_type   state_q;
   logic [2:0]  clk_s_q;
   logic [7:0]  byte_m_q;
   logic [7:0]  byte_s_q;
   logic [1:0]  sel_s_q;
   logic [1:0]  rcfg_s_q;
   logic [5:0]  mode_m_q;
   logic [2:0]  hdr_cnt_q;
   logic [15:0] byte_cnt_q;
   logic [15:0] frame_cnt_q;
   logic [2:0]  startup_q;
   logic        rise;
   logic        express;
   logic        restart;

   // Two-stage synchronisers; the third clock stage only finds edges
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clk_s_q  <= '0;
         byte_m_q <= '0;
         byte_s_q <= '0;
         sel_s_q  <= '0;
         rcfg_s_q <= 2'b11;
         mode_m_q <= '0;
      end else begin
         clk_s_q  <= {clk_s_q[1:0], link.config_clock};
         byte_m_q <= link.config_byte_bus;
         byte_s_q <= byte_m_q;
         sel_s_q  <= {sel_s_q[0], link.chain_select};
         rcfg_s_q <= {rcfg_s_q[0], link.reconfig_b};
         mode_m_q <= {mode_m_q[2:0], link.mode_select};
      end
   end

   assign rise    = clk_s_q[1] && !clk_s_q[2];
   assign express = mode_m_q[5:3] == MODE_EXPRESS;
   assign restart = !rcfg_s_q[1];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q     <= S_HEADER;
         hdr_cnt_q   <= '0;
         byte_cnt_q  <= '0;
         frame_cnt_q <= '0;
      end else if (restart || !express) begin
         state_q     <= S_HEADER;
         hdr_cnt_q   <= '0;
         byte_cnt_q  <= '0;
         frame_cnt_q <= '0;
      end else if (rise) begin
         case (state_q)
            S_HEADER: begin
               if (byte_s_q != header_byte(hdr_cnt_q)) begin
                  state_q <= S_ERROR;
               end else if (hdr_cnt_q == 3'(HEADER_LEN - 1)) begin
                  state_q <= S_WAIT;
               end else begin
                  hdr_cnt_q <= hdr_cnt_q + 1'b1;
               end
            end
            S_WAIT, S_START: begin
               if (sel_s_q[1]) begin
                  if (to_bus({START_BITS, 1'b0}) == {1'b0, byte_s_q[6:0]}) begin
                     state_q    <= S_DATA;
                     byte_cnt_q <= '0;
                  end else begin
                     state_q <= S_ERROR;
                  end
               end
            end
            S_DATA: begin
               if (sel_s_q[1]) begin
                  if (byte_cnt_q == 16'(FRAME_LEN - 1)) begin
                     state_q <= S_CHECK;
                  end
                  byte_cnt_q <= byte_cnt_q + 1'b1;
               end
            end
            S_CHECK: begin
               if (sel_s_q[1]) begin
                  if (byte_s_q != to_bus(CHECK_BITS)) begin
                     state_q <= S_ERROR;
                  end else if (frame_cnt_q == 16'(NUM_FRAMES - 1)) begin
                     state_q <= S_FULL;
                  end else begin
                     state_q     <= S_START;
                     frame_cnt_q <= frame_cnt_q + 1'b1;
                  end
               end
            end
            default: begin
               state_q <= state_q;
            end
         endcase
      end
   end

   // done after start-up clocks, no length count
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         startup_q <= '0;
      end else if (restart || state_q != S_FULL) begin
         startup_q <= '0;
      end else if (rise && startup_q != 3'(STARTUP_MIN)) begin
         startup_q <= startup_q + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         link.chain_status <= 1'b1;
         link.init_o       <= 1'b0;
         link.init_oe      <= 1'b0;
         link.done         <= 1'b0;
         loaded            <= 1'b0;
         frame_error       <= 1'b0;
      end else begin
         link.chain_status <= state_q == S_HEADER || state_q == S_FULL;
         link.init_o       <= 1'b0;
         link.init_oe      <= state_q == S_ERROR;
         link.done         <= startup_q == 3'(STARTUP_MIN);
         loaded            <= state_q == S_FULL;
         frame_error       <= state_q == S_ERROR;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         frame_byte  <= '0;
         frame_valid <= 1'b0;
      end else begin
         frame_byte  <= byte_s_q;
         frame_valid <= rise && state_q == S_DATA && sel_s_q[1] && express && !restart;
      end
   end
endmodule : cfg_loader
`default_nettype wire

// ### cfg_loader_pkg.sv
// Constants shared by the byte-wide express configuration loader and its source.
// Assumes both ends run on one 125 MHz clock and share the link interface.
package cfg_loader_pkg;
   localparam int          HEADER_LEN    = 7;
   localparam logic [7:0]  FILL_BYTE     = 8'hff;
   // Stream bits in line order: line zero is the leftmost bit
   localparam logic [7:0]  PREAMBLE_BITS = 8'b11110010;
   localparam logic [7:0]  CHECK_BITS    = 8'b11010010;
   localparam logic [6:0]  START_BITS    = 7'b1111110;
   localparam int          PREAMBLE_POS  = 2;
   localparam int          STARTUP_MIN   = 6;
   localparam int          CLK_PERIOD_NS = 8;
   localparam int          LINK_HALF_NS  = 64;
   localparam int          LINK_HALF_CYC = LINK_HALF_NS / CLK_PERIOD_NS;
   localparam int          DEF_FRAME_LEN = 8;
   localparam int          DEF_FRAMES    = 4;
   localparam int          FIFO_DEPTH    = 32;
   localparam logic [2:0]  MODE_EXPRESS  = 3'b010;

   // Maps a stream pattern (leftmost first) onto the bus lines 0..7
   function automatic logic [7:0] to_bus(input logic [7:0] pat);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         r[i] = pat[7 - i];
      end
      return r;
   endfunction : to_bus

   function automatic logic [7:0] header_byte(input logic [2:0] idx);
      logic [7:0] r;
      r = FILL_BYTE;
      if (idx == 3'(PREAMBLE_POS)) begin
         r = PREAMBLE_BITS;
      end else if (idx == 3'(HEADER_LEN - 1)) begin
         r = CHECK_BITS;
      end
      return to_bus(r);
   endfunction : header_byte
endpackage : cfg_loader_pkg

// ### cfg_source.sv
// Source end: builds the express stream from user bytes via a FIFO.
// Makes the configuration clock by dividing its own clock.
`timescale 1ns/100ps
`default_nettype none
module cfg_source
   import cfg_loader_pkg::*;
#(
   parameter int FRAME_LEN  = DEF_FRAME_LEN,
   parameter int NUM_FRAMES = DEF_FRAMES,
   parameter int EXTRA_UP   = 2
) (
   input  wire logic clk,
   input  wire logic rst_b,
   cfg_link_if.source link,
   input  wire logic       start,
   input  wire logic [7:0] user_data,
   input  wire logic       user_valid,
   output var  logic       user_ready,
   output var  logic       busy,
   output var  logic       failed
);
   initial begin
      if (FRAME_LEN < 1 || NUM_FRAMES < 1 || EXTRA_UP < 0) $error("stream shape must be positive");
   end

   typedef enum logic [2:0] {
      T_IDLE  = 3'b000,
      T_HDR   = 3'b001,
      T_START = 3'b011,
      T_DATA  = 3'b010,
      T_CHECK = 3'b110,
      T_UP    = 3'b111
   } state_type;

   state_type   state_q;
   logic [3:0]  div_q;
   logic [15:0] cnt_q;
   logic [15:0] frame_q;
   logic [1:0]  init_s_q;
   logic        fall;
   logic        tick;
   logic        take;
   logic [7:0]  f_data;
   logic        f_valid;
   logic        f_pop;
   logic        fifo_rdy;

   cfg_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .rst_b     (rst_b),
      .in_data   (user_data),
      .in_valid  (user_valid),
      .in_ready  (fifo_rdy),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (f_pop)
   );

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         user_ready <= 1'b0;
      end else begin
         user_ready <= fifo_rdy;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_q              <= '0;
         link.config_clock  <= 1'b0;
      end else if (tick) begin
         div_q             <= '0;
         // Clock stands low while idle so the loader sees no stray edges
         link.config_clock <= state_q != T_IDLE && !link.config_clock;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end
   assign tick  = div_q == 4'(LINK_HALF_CYC - 1);
   // New byte presented on falling edge, loader takes it on rising
   assign fall  = tick && link.config_clock;
   // Start only from a low clock, so the first byte gets a full low phase
   assign take  = tick && !link.config_clock && state_q == T_IDLE && start;
   // Data stalls at falling edge if FIFO is empty: clock keeps running, frame byte waits
   assign f_pop = fall && state_q == T_DATA && f_valid;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         init_s_q <= 2'b11;
      end else begin
         init_s_q <= {init_s_q[0], link.init_b};
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q              <= T_IDLE;
         cnt_q                <= '0;
         frame_q              <= '0;
         link.config_byte_bus <= '0;
         failed               <= 1'b0;
      end else if (state_q != T_IDLE && !init_s_q[1]) begin
         state_q <= T_IDLE;
         failed  <= 1'b1;
      end else if (state_q == T_IDLE) begin
         if (take) begin
            failed               <= 1'b0;
            state_q              <= T_HDR;
            cnt_q                <= 16'd1;
            frame_q              <= '0;
            link.config_byte_bus <= header_byte(3'd0);
         end
      end else if (fall) begin
         case (state_q)
            T_HDR: begin
               if (cnt_q == 16'(HEADER_LEN)) begin
                  state_q              <= T_DATA;
                  cnt_q                <= '0;
                  link.config_byte_bus <= to_bus({START_BITS, 1'b0});
               end else begin
                  link.config_byte_bus <= header_byte(cnt_q[2:0]);
                  cnt_q                <= cnt_q + 1'b1;
               end
            end
            T_START: begin
               state_q              <= T_DATA;
               cnt_q                <= '0;
               link.config_byte_bus <= to_bus({START_BITS, 1'b0});
            end
            T_DATA: begin
               if (f_valid) begin
                  link.config_byte_bus <= f_data;
                  if (cnt_q == 16'(FRAME_LEN - 1)) begin
                     state_q <= T_CHECK;
                  end
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            T_CHECK: begin
               link.config_byte_bus <= to_bus(CHECK_BITS);
               if (frame_q == 16'(NUM_FRAMES - 1)) begin
                  state_q <= T_UP;
                  cnt_q   <= '0;
               end else begin
                  state_q <= T_START;
                  frame_q <= frame_q + 1'b1;
               end
            end
            T_UP: begin
               link.config_byte_bus <= FILL_BYTE;
               if (cnt_q == 16'(STARTUP_MIN + EXTRA_UP)) begin
                  state_q <= T_IDLE;
                  frame_q <= '0;
               end
               cnt_q <= cnt_q + 1'b1;
            end
            default: begin
               state_q <= T_IDLE;
            end
         endcase
      end
   end

   // pulse low before each load and on failure
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         link.reconfig_b <= 1'b0;
      end else begin
         link.reconfig_b <= !(take || (state_q != T_IDLE && !init_s_q[1]));
      end
   end

   // select held while loading; mode pins
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         link.chain_select <= 1'b0;
         link.mode_select  <= MODE_EXPRESS;
         busy              <= 1'b0;
      end else begin
         link.chain_select <= state_q != T_IDLE;
         link.mode_select  <= MODE_EXPRESS;
         busy              <= state_q != T_IDLE;
      end
   end
endmodule : cfg_source
`default_nettype wire

// ### test_bytewide_express_config_loader.sv
// Bench: source and loader face each other on link_a; a second loader on
// link_b is fed straight from the bench so streams can be broken on purpose.
`timescale 1ns/100ps
`default_nettype none
module test_bytewide_express_config_loader
   import cfg_loader_pkg::*;
;
   localparam int         FL_B = 2;
   localparam int         NF_B = 2;
   localparam logic [7:0] HDR [0:6] = '{8'hff, 8'hff, 8'h4f, 8'hff, 8'hff, 8'hff, 8'h4b};
   logic       clk, rst_b, start, user_valid, user_ready, busy, failed;
   logic [7:0] user_data, fbyte_a, fbyte_b;
   logic       fvalid_a, ferr_a, loaded_a, fvalid_b, ferr_b, loaded_b;
   logic [7:0] got_a[$];
   int         err_total, compares, nb;

   cfg_link_if link_a ();
   cfg_link_if link_b ();
   cfg_source cfg_source_inst (.clk(clk), .rst_b(rst_b), .link(link_a), .start(start), .user_data(user_data),
      .user_valid(user_valid), .user_ready(user_ready), .busy(busy), .failed(failed));
   cfg_loader cfg_loader_inst (.clk(clk), .rst_b(rst_b), .link(link_a), .frame_byte(fbyte_a),
      .frame_valid(fvalid_a), .frame_error(ferr_a), .loaded(loaded_a));
   cfg_loader #(.FRAME_LEN(FL_B), .NUM_FRAMES(NF_B)) cfg_loader_b_inst (.clk(clk), .rst_b(rst_b), .link(link_b),
      .frame_byte(fbyte_b), .frame_valid(fvalid_b), .frame_error(ferr_b), .loaded(loaded_b));
   cfg_link_sva cfg_link_sva_inst (.clk(clk), .rst_b(rst_b), .config_clock(link_a.config_clock),
      .config_byte_bus(link_a.config_byte_bus), .chain_select(link_a.chain_select),
      .chain_status(link_a.chain_status), .reconfig_b(link_a.reconfig_b), .mode_select(link_a.mode_select),
      .init_o(link_a.init_o), .init_oe(link_a.init_oe), .init_b(link_a.init_b), .done(link_a.done));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk) begin
      if (fvalid_a === 1'b1) got_a.push_back(fbyte_a);
      if (fvalid_b === 1'b1) nb++;
   end

   task automatic cmp_bit(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
      end
   endtask : cmp_bit

   task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp_byte

   task automatic conclude();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   // Bench link clock, 125 ns; bus changes only with the fall
   task automatic link_byte(input logic [7:0] b);
      link_b.config_byte_bus <= b;
      #62.5 link_b.config_clock <= 1'b1;
      #62.5 link_b.config_clock <= 1'b0;
   endtask : link_byte

   task automatic send_frame(input logic [7:0] check);
      link_byte(8'h3f);
      for (int k = 0; k < FL_B; k++) link_byte(8'h10 + 8'(k));
      link_byte(check);
   endtask : send_frame

   task automatic restart_b();
      @(posedge clk);
      link_b.reconfig_b <= 1'b0;
      repeat (4) @(posedge clk);
      link_b.reconfig_b <= 1'b1;
      repeat (4) @(posedge clk);
   endtask : restart_b

   task automatic check_reset();
      cmp_bit("status at reset", 1'b1, link_a.chain_status);
      cmp_bit("init at reset", 1'b1, link_a.init_b);
      cmp_bit("done at reset", 1'b0, link_a.done);
      cmp_byte("mode pins", 8'h02, {5'h00, link_a.mode_select});
   endtask : check_reset

   // Fills the buffer until it refuses, then streams it all across
   task automatic run_load(input logic [7:0] seed);
      logic [7:0] sent[$];
      int         n;
      sent = {};
      got_a = {};
      n = 0;
      while (n < FIFO_DEPTH) begin
         @(posedge clk);
         user_valid <= (user_ready === 1'b1);
         user_data <= seed + 8'(n * 37);
         if (user_ready === 1'b1) sent.push_back(seed + 8'(n * 37));
         if (user_ready === 1'b1) n++;
      end
      @(posedge clk);
      user_valid <= 1'b0;
      repeat (3) @(posedge clk);
      cmp_bit("buffer refuses", 1'b0, user_ready);
      start <= 1'b1;
      for (n = 0; n < 400 && busy !== 1'b1; n++) @(posedge clk);
      start <= 1'b0;
      for (n = 0; n < 2000 && link_a.chain_status !== 1'b0; n++) @(posedge clk);
      cmp_bit("status low after header", 1'b0, link_a.chain_status);
      cmp_bit("loaded cleared", 1'b0, loaded_a);
      for (n = 0; n < 5000 && link_a.done !== 1'b1; n++) @(posedge clk);
      cmp_bit("done", 1'b1, link_a.done);
      cmp_bit("loaded", 1'b1, loaded_a);
      cmp_bit("frame error", 1'b0, ferr_a);
      cmp_bit("init high", 1'b1, link_a.init_b);
      cmp_bit("status when full", 1'b1, link_a.chain_status);
      cmp_byte("byte count", 8'(FIFO_DEPTH), 8'(got_a.size()));
      foreach (sent[i]) cmp_byte("frame byte", sent[i], (i < got_a.size()) ? got_a[i] : 8'hxx);
      for (n = 0; n < 2000 && busy !== 1'b0; n++) @(posedge clk);
      cmp_bit("source failed", 1'b0, failed);
   endtask : run_load

   task automatic run_chain();
      restart_b();
      link_b.chain_select <= 1'b0;
      foreach (HDR[i]) link_byte(HDR[i]);
      repeat (6) @(posedge clk);
      cmp_bit("status after header", 1'b0, link_b.chain_status);
      nb = 0;
      send_frame(8'h4b);
      repeat (6) @(posedge clk);
      cmp_byte("bytes unselected", 8'h00, 8'(nb));
      // select held for the rest of the load
      link_b.chain_select <= 1'b1;
      repeat (NF_B) send_frame(8'h4b);
      repeat (6) @(posedge clk);
      cmp_byte("bytes selected", 8'(FL_B * NF_B), 8'(nb));
      cmp_bit("status when full", 1'b1, link_b.chain_status);
      // one start-up clock short of six
      repeat (STARTUP_MIN - 1) link_byte(8'hff);
      repeat (6) @(posedge clk);
      cmp_bit("done after five", 1'b0, link_b.done);
      link_byte(8'hff);
      repeat (6) @(posedge clk);
      cmp_bit("done after six", 1'b1, link_b.done);
      cmp_bit("loaded", 1'b1, loaded_b);
      send_frame(8'h4b);
      repeat (6) @(posedge clk);
      cmp_byte("bytes after full", 8'(FL_B * NF_B), 8'(nb));
   endtask : run_chain

   task automatic run_bad_check();
      restart_b();
      nb = 0;
      foreach (HDR[i]) link_byte(HDR[i]);
      // One line wrong in the check byte
      send_frame(8'h4a);
      repeat (4) @(posedge clk);
      cmp_bit("init low", 1'b0, link_b.init_b);
      cmp_bit("init pulled only", 1'b0, link_b.init_o);
      cmp_bit("error flag", 1'b1, ferr_b);
      send_frame(8'h4b);
      repeat (6) @(posedge clk);
      cmp_byte("bytes after error", 8'(FL_B), 8'(nb));
      cmp_bit("init held", 1'b0, link_b.init_b);
      restart_b();
      cmp_bit("init released", 1'b1, link_b.init_b);
      cmp_bit("error cleared", 1'b0, ferr_b);
      foreach (HDR[i]) link_byte(HDR[i]);
      // Line six high breaks the start field
      link_byte(8'h7f);
      repeat (4) @(posedge clk);
      cmp_bit("start field error", 1'b1, ferr_b);
      link_b.mode_select <= 3'h0;
      repeat (6) @(posedge clk);
      cmp_bit("error cleared off express", 1'b0, ferr_b);
      link_b.mode_select <= 3'h2;
   endtask : run_bad_check

   initial begin
      err_total = 0;
      compares = 0;
      nb = 0;
      rst_b = 1'b0;
      start = 1'b0;
      user_valid = 1'b0;
      user_data = 8'h00;
      link_b.config_clock = 1'b0;
      link_b.config_byte_bus = 8'hff;
      link_b.chain_select = 1'b0;
      link_b.reconfig_b = 1'b0;
      link_b.mode_select = 3'h2;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      check_reset();
      run_load(8'h01);
      run_load(8'h80);
      #3.3;
      run_chain();
      run_bad_check();
      conclude();
   end

   // Whole run is near 3k cycles; this allows the 50k-cycle limit, over sixteen times that
   initial begin
      #400000;
      err_total++;
      $display("MISMATCH watchdog expected finish seen timeout");
      conclude();
   end
endmodule : test_bytewide_express_config_loader
`default_nettype wire
